// ---- rtl/mpo_pkg.sv ----
// Constants for the motor PWM output stage: register map, field layout,
// timebase mode codes and reset values.
// Assumes a 16-bit register port with a 4-bit word address.
package mpo_pkg;

  // ************************************************************
  // Register offsets (word addresses)
  // ************************************************************
  localparam logic [3:0] OFF_DUTY0 = 4'h0;
  localparam logic [3:0] OFF_DEAD_VALUES = 4'h4;
  localparam logic [3:0] OFF_DEAD_ASSIGN = 4'h5;
  localparam logic [3:0] OFF_OVERRIDE = 4'h6;
  localparam logic [3:0] OFF_MODE_CTRL = 4'h7;
  localparam logic [3:0] OFF_STATUS = 4'h8;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int DT_A_CNT_LSB = 0;
  localparam int DT_A_PS_LSB = 6;
  localparam int DT_B_CNT_LSB = 8;
  localparam int DT_B_PS_LSB = 14;
  localparam int OVD_STATE_LSB = 0;
  localparam int OVD_SEL_LSB = 8;
  localparam int CTL_PMOD_LSB = 0;
  localparam int CTL_IUE_BIT = 4;

  // ************************************************************
  // Widths, modes and reset values
  // ************************************************************
  localparam int NUM_PAIRS = 4;
  localparam int DT_W = 6;
  localparam int CTL_W = 5;
  localparam logic [1:0] MODE_FREE_RUN = 2'h0;
  localparam logic [1:0] MODE_UP_DOWN = 2'h1;
  localparam logic [1:0] MODE_SINGLE_PULSE = 2'h2;
  localparam logic [1:0] MODE_UP_DOWN_DOUBLE = 2'h3;
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [4:0] RST_MODE_CTRL = 5'h00;
  localparam logic [5:0] RST_DEAD_CNT = 6'h00;
  localparam logic [2:0] RST_PRESCALE = 3'h0;

endpackage : mpo_pkg

// ---- rtl/mpo_output_stage.sv ----
// Output stage of a four-pair motor PWM generator: duty buffers, compare,
// dead time, override and pin drive.
// Assumes the timebase (count, direction, period match, run flag) runs on
// the same clock and that software uses the one-cycle register port.
`timescale 1ns/100ps
module mpo_output_stage (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic [14:0] timebase_count_in,
  input wire logic timebase_down_in,
  input wire logic period_match_in,
  input wire logic timebase_run_flag_in,
  input wire logic [1:0] timebase_mode_field_in,
  input wire logic update_lockout_in,
  output logic single_pulse_end_out,
  output logic [3:0] pair_high_output_out,
  output logic [3:0] pair_low_output_out
);

  // ************************************************************
  // State
  // ************************************************************
  logic [15:0] buf_q [4];
  logic [15:0] buf_d [4];
  logic [15:0] act_q [4];
  logic [15:0] act_d [4];
  logic [15:0] dead_values_q, dead_values_d;
  logic [15:0] dead_assign_q, dead_assign_d;
  logic [15:0] override_q, override_d;
  logic [4:0] mode_ctrl_q, mode_ctrl_d;
  logic [15:0] rdata_q, rdata_d;
  logic [3:0] cmp_q, cmp_d;
  logic [3:0] src_q, src_d;
  logic [3:0] hi_q, hi_d;
  logic [3:0] lo_q, lo_d;
  logic [3:0] psel_q, psel_d;
  logic [5:0] cnt_q [4];
  logic [5:0] cnt_d [4];
  logic [2:0] pre_q [4];
  logic [2:0] pre_d [4];
  logic spend_q, spend_d;

  logic [3:0] imm_wr;
  logic dead_wr;
  logic upd_raw;
  logic upd_now;
  logic count_zero;
  logic single_mode;

  function automatic logic [2:0] ps_limit(input logic [1:0] ps);
    ps_limit = 3'((4'h1 << ps) - 4'h1);
  endfunction : ps_limit

  assign count_zero = (timebase_count_in == 15'h0000);
  assign single_mode = (timebase_mode_field_in == mpo_pkg::MODE_SINGLE_PULSE);
  assign dead_wr = reg_wr_in && ((reg_addr_in == mpo_pkg::OFF_DEAD_VALUES) ||
                                 (reg_addr_in == mpo_pkg::OFF_DEAD_ASSIGN));

  // ************************************************************
  // Register port
  // ************************************************************
  always_comb begin
    dead_values_d = dead_values_q;
    dead_assign_d = dead_assign_q;
    override_d = override_q;
    mode_ctrl_d = mode_ctrl_q;
    rdata_d = 16'h0000;
    for (int i = 0; i < mpo_pkg::NUM_PAIRS; i++) begin
      buf_d[i] = buf_q[i];
      imm_wr[i] = 1'b0;
      if (reg_wr_in && (reg_addr_in == 4'(mpo_pkg::OFF_DUTY0 + 4'(i)))) begin
        buf_d[i] = reg_wdata_in;
        imm_wr[i] = mode_ctrl_q[mpo_pkg::CTL_IUE_BIT];
      end
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        mpo_pkg::OFF_DEAD_VALUES: dead_values_d = reg_wdata_in;
        mpo_pkg::OFF_DEAD_ASSIGN: dead_assign_d = reg_wdata_in;
        mpo_pkg::OFF_OVERRIDE: override_d = reg_wdata_in;
        mpo_pkg::OFF_MODE_CTRL: mode_ctrl_d = reg_wdata_in[4:0];
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        4'h0, 4'h1, 4'h2, 4'h3: rdata_d = buf_q[reg_addr_in[1:0]];
        mpo_pkg::OFF_DEAD_VALUES: rdata_d = dead_values_q;
        mpo_pkg::OFF_DEAD_ASSIGN: rdata_d = dead_assign_q;
        mpo_pkg::OFF_OVERRIDE: rdata_d = override_q;
        mpo_pkg::OFF_MODE_CTRL: rdata_d = {11'h000, mode_ctrl_q};
        mpo_pkg::OFF_STATUS: rdata_d = {4'h0, cmp_q, lo_q, hi_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < mpo_pkg::NUM_PAIRS; i++) begin
        buf_q[i] <= mpo_pkg::RST_REG16;
      end
      dead_values_q <= mpo_pkg::RST_REG16;
      dead_assign_q <= mpo_pkg::RST_REG16;
      override_q <= mpo_pkg::RST_REG16;
      mode_ctrl_q <= mpo_pkg::RST_MODE_CTRL;
      rdata_q <= mpo_pkg::RST_REG16;
    end else begin
      buf_q <= buf_d;
      dead_values_q <= dead_values_d;
      dead_assign_q <= dead_assign_d;
      override_q <= override_d;
      mode_ctrl_q <= mode_ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // ************************************************************
  // Active duty transfer and compare
  // ************************************************************
  always_comb begin
    case (timebase_mode_field_in)
      mpo_pkg::MODE_FREE_RUN, mpo_pkg::MODE_SINGLE_PULSE:
        upd_raw = period_match_in || !timebase_run_flag_in;
      mpo_pkg::MODE_UP_DOWN:
        upd_raw = (count_zero && !timebase_down_in && timebase_run_flag_in) ||
                  !timebase_run_flag_in;
      mpo_pkg::MODE_UP_DOWN_DOUBLE:
        upd_raw = (count_zero && timebase_run_flag_in) || period_match_in ||
                  !timebase_run_flag_in;
      default: upd_raw = 1'b0;
    endcase
    upd_now = upd_raw && !update_lockout_in;
    spend_d = single_mode && period_match_in && timebase_run_flag_in;
    for (int i = 0; i < mpo_pkg::NUM_PAIRS; i++) begin
      if (imm_wr[i]) begin
        act_d[i] = reg_wdata_in;
      end else if (upd_now) begin
        act_d[i] = buf_q[i];
      end else begin
        act_d[i] = act_q[i];
      end
      // Level compare gives shorten, lengthen and immediate start for free
      cmp_d[i] = ({1'b0, timebase_count_in} < act_d[i]);
      if (single_mode && (!timebase_run_flag_in || period_match_in)) begin
        cmp_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < mpo_pkg::NUM_PAIRS; i++) begin
        act_q[i] <= mpo_pkg::RST_REG16;
      end
      cmp_q <= 4'h0;
      spend_q <= 1'b0;
    end else begin
      act_q <= act_d;
      cmp_q <= cmp_d;
      spend_q <= spend_d;
    end
  end

  // ************************************************************
  // Override, dead time and pin drive
  // ************************************************************
  always_comb begin
    logic sel_h, sel_l, st_h, st_l, hsrc, indep, edge_ev, rising, pick;
    logic [5:0] load_val;
    sel_h = 1'b0;
    sel_l = 1'b0;
    st_h = 1'b0;
    st_l = 1'b0;
    hsrc = 1'b0;
    indep = 1'b0;
    edge_ev = 1'b0;
    rising = 1'b0;
    pick = 1'b0;
    load_val = 6'h00;
    for (int i = 0; i < mpo_pkg::NUM_PAIRS; i++) begin
      sel_h = override_q[mpo_pkg::OVD_SEL_LSB + 2 * i + 1];
      sel_l = override_q[mpo_pkg::OVD_SEL_LSB + 2 * i];
      st_h = override_q[mpo_pkg::OVD_STATE_LSB + 2 * i + 1];
      st_l = override_q[mpo_pkg::OVD_STATE_LSB + 2 * i];
      hsrc = sel_h ? st_h : cmp_q[i];
      indep = mode_ctrl_q[mpo_pkg::CTL_PMOD_LSB + i];
      edge_ev = (hsrc != src_q[i]);
      rising = hsrc && !src_q[i];
      // Active edge and inactive edge each pick value A or B
      pick = rising ? dead_assign_q[2 * i] : dead_assign_q[2 * i + 1];
      load_val = pick ? dead_values_q[mpo_pkg::DT_B_CNT_LSB +: mpo_pkg::DT_W] :
                        dead_values_q[mpo_pkg::DT_A_CNT_LSB +: mpo_pkg::DT_W];
      src_d[i] = hsrc;
      psel_d[i] = psel_q[i];
      cnt_d[i] = cnt_q[i];
      pre_d[i] = pre_q[i];
      if (indep) begin
        cnt_d[i] = mpo_pkg::RST_DEAD_CNT;
        pre_d[i] = mpo_pkg::RST_PRESCALE;
      end else if (edge_ev) begin
        cnt_d[i] = load_val;
        pre_d[i] = mpo_pkg::RST_PRESCALE;
        psel_d[i] = pick;
      end else if (cnt_q[i] != 6'h00) begin
        if (pre_q[i] == ps_limit(psel_q[i] ? dead_values_q[mpo_pkg::DT_B_PS_LSB +: 2] :
                                             dead_values_q[mpo_pkg::DT_A_PS_LSB +: 2])) begin
          pre_d[i] = mpo_pkg::RST_PRESCALE;
          cnt_d[i] = cnt_q[i] - 6'h01;
        end else begin
          pre_d[i] = pre_q[i] + 3'h1;
        end
      end
      if (dead_wr) begin
        pre_d[i] = mpo_pkg::RST_PRESCALE;
      end
      if (indep) begin
        hi_d[i] = hsrc;
        lo_d[i] = sel_l ? st_l : cmp_q[i];
      end else begin
        // Dead interval keeps both transistors off
        hi_d[i] = hsrc && (cnt_d[i] == 6'h00);
        lo_d[i] = !hsrc && (cnt_d[i] == 6'h00) && !(sel_l && !st_l);
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < mpo_pkg::NUM_PAIRS; i++) begin
        cnt_q[i] <= mpo_pkg::RST_DEAD_CNT;
        pre_q[i] <= mpo_pkg::RST_PRESCALE;
      end
      src_q <= 4'h0;
      psel_q <= 4'h0;
      hi_q <= 4'h0;
      lo_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      src_q <= src_d;
      psel_q <= psel_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign single_pulse_end_out = spend_q;
  assign pair_high_output_out = hi_q;
  assign pair_low_output_out = lo_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  duty_hold_a: assert property (!upd_now && !imm_wr[0] |=> $stable(act_q[0]))
    else $error("active duty changed without a transfer");
  edge_load_a: assert property ((timebase_mode_field_in == mpo_pkg::MODE_FREE_RUN) && period_match_in &&
      !update_lockout_in && !reg_wr_in |=> act_q[1] == $past(buf_q[1]))
    else $error("period match did not load the duty buffer");
  idle_load_a: assert property ((timebase_mode_field_in == mpo_pkg::MODE_FREE_RUN) && !timebase_run_flag_in &&
      !update_lockout_in && !reg_wr_in |=> act_q[2] == $past(buf_q[2]))
    else $error("stopped timebase did not load the duty buffer");
  updown_load_a: assert property ((timebase_mode_field_in == mpo_pkg::MODE_UP_DOWN) && count_zero &&
      !timebase_down_in && !update_lockout_in && !reg_wr_in |=> act_q[3] == $past(buf_q[3]))
    else $error("up/down zero did not load the duty buffer");
  double_load_a: assert property ((timebase_mode_field_in == mpo_pkg::MODE_UP_DOWN_DOUBLE) && period_match_in &&
      !update_lockout_in && !reg_wr_in |=> act_q[0] == $past(buf_q[0]))
    else $error("double update period match did not load");
  imm_write_a: assert property (imm_wr[0] |=> act_q[0] == $past(reg_wdata_in))
    else $error("immediate duty write not applied");
  imm_shorten_a: assert property (imm_wr[0] && !single_mode &&
      ({1'b0, timebase_count_in} >= reg_wdata_in) |=> !cmp_q[0])
    else $error("short duty did not end the pulse");
  imm_start_a: assert property (imm_wr[0] && !single_mode &&
      ({1'b0, timebase_count_in} < reg_wdata_in) |=> cmp_q[0])
    else $error("long duty did not start the pulse");
  lockout_hold_a: assert property (update_lockout_in && !imm_wr[1] |=> $stable(act_q[1]))
    else $error("transfer during update lockout");
  comp_excl_a: assert property (!mode_ctrl_q[0] && $past(!mode_ctrl_q[0]) |-> !(hi_q[0] && lo_q[0]))
    else $error("complementary pair both active");
  dead_gap_a: assert property (!mode_ctrl_q[1] && (cnt_q[1] != 6'h00) |-> !hi_q[1] && !lo_q[1])
    else $error("pin active during dead time");
  indep_pass_a: assert property (mode_ctrl_q[2] && !override_q[13] |=> hi_q[2] == $past(cmp_q[2]))
    else $error("independent high pin not following compare");
  single_end_a: assert property (single_mode && period_match_in |=> cmp_q == 4'h0)
    else $error("single pulse outputs not cleared at period match");
  prescale_clr_a: assert property (dead_wr |=> pre_q[3] == 3'h0)
    else $error("prescaler not cleared by dead register write");

  dead_run_c: cover property (!mode_ctrl_q[0] && cnt_q[0] == 6'h01 ##1 cnt_q[0] == 6'h00);
  imm_wr_c: cover property (imm_wr[0] && cmp_q[0]);
  single_end_c: cover property (spend_q);
  override_c: cover property (override_q[8] && !override_q[0] && !mode_ctrl_q[0]);

endmodule : mpo_output_stage

// ---- sim/mpo_gate_model.sv ----
// Gate driver model for the four high/low transistor pairs.
// Assumes active-high registered pins on the same clock as the stage.
`timescale 1ns/100ps
module mpo_gate_model (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] high_gate_in,
  input wire logic [3:0] low_gate_in,
  input wire logic [3:0] indep_in,
  output logic [3:0] shoot_thru_out
);
  logic [3:0] shoot_thru_q;
  logic [3:0] shoot_thru_d;
  // Sticky, so a single-cycle overlap on a complementary pair is never lost
  always_comb begin
    shoot_thru_d = shoot_thru_q | (high_gate_in & low_gate_in & ~indep_in);
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shoot_thru_q <= 4'h0;
    end else begin
      shoot_thru_q <= shoot_thru_d;
    end
  end
  assign shoot_thru_out = shoot_thru_q;
endmodule : mpo_gate_model

// ---- sim/tb.sv ----
// Self-checking bench for the motor PWM output stage.
// Assumes the design package, the stage and the gate driver model compile first.
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic pin; logic [15:0] val;} mpo_exp_t;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [14:0] cnt = 15'h0064;
  logic dn = 1'b0;
  logic pm = 1'b0;
  logic run = 1'b0;
  logic [1:0] mode = 2'h0;
  logic lock = 1'b0;
  logic sp_end;
  logic [3:0] hi;
  logic [3:0] lo;
  logic [3:0] shoot;
  logic [3:0] indep = 4'h0;
  logic rd_q = 1'b0;
  logic look = 1'b0;
  logic [15:0] lfsr = 16'h3632;
  logic [15:0] act [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [3:0] ab;
  mpo_exp_t exp_q [$];
  mpo_exp_t e;
  int bad_count = 0;
  int num_checks = 0;
  int gap;
  always #20 ref_clk_in = ~ref_clk_in;
  mpo_output_stage mpo_output_stage_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .timebase_count_in(cnt),
    .timebase_down_in(dn), .period_match_in(pm), .timebase_run_flag_in(run), .timebase_mode_field_in(mode),
    .update_lockout_in(lock), .single_pulse_end_out(sp_end), .pair_high_output_out(hi),
    .pair_low_output_out(lo));
  mpo_gate_model mpo_gate_model_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .high_gate_in(hi),
    .low_gate_in(lo), .indep_in(indep), .shoot_thru_out(shoot));
  // ************************************************************
  // Checking helpers
  // ************************************************************
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check
  always @(posedge ref_clk_in) rd_q <= rd;
  // Read data stands only in the cycle after the strobe
  always @(negedge ref_clk_in) begin
    if (rd_q || look) begin
      e = exp_q.pop_front();
      if (e.pin) check({sp_end, 3'h0, hi, 4'h0, lo} === e.val, "pins");
      else check(rdata === e.val, "read data");
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : step
  // Bus tasks leave one idle cycle so no strobe is driven twice at one edge
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    @(posedge ref_clk_in);
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] x);
    exp_q.push_back({1'b0, x});
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    @(posedge ref_clk_in);
  endtask : rd_reg
  task automatic pins(input logic s, input logic [3:0] h, input logic [3:0] l);
    exp_q.push_back({1'b1, s, 3'h0, h, 4'h0, l});
    look <= 1'b1;
    @(posedge ref_clk_in);
    look <= 1'b0;
    @(posedge ref_clk_in);
  endtask : pins
  function automatic logic [3:0] above();
    for (int i = 0; i < 4; i++) above[i] = act[i] > {1'b0, cnt};
  endfunction : above
  task automatic boundary(input logic [1:0] m, input logic [14:0] c, input logic d, input logic p, input logic ld);
    logic [15:0] nv;
    nv = (act[0] > 16'h0064) ? 16'h0000 : 16'h00c8;
    mode <= m;
    wr_reg(mpo_pkg::OFF_DUTY0, nv);
    cnt <= c;
    dn <= d;
    pm <= p;
    @(posedge ref_clk_in);
    cnt <= 15'h0064;
    dn <= 1'b0;
    pm <= 1'b0;
    step(3);
    if (ld) act[0] = nv;
    pins(1'b0, above(), above());
  endtask : boundary
  task automatic dead_gap(input logic to_hi, input int lo_b, input int hi_b);
    int k;
    gap = 0;
    for (k = 0; k < 40 && (to_hi ? hi[0] : lo[0]) !== 1'b1; k++) begin
      @(negedge ref_clk_in);
      if (hi[0] === 1'b0 && lo[0] === 1'b0) gap++;
    end
    check(k < 40 && gap >= lo_b && gap <= hi_b, "dead time length");
  endtask : dead_gap
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    step(4);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 8; i++) rd_reg(i[3:0], 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr_reg(mpo_pkg::OFF_DEAD_VALUES + i[3:0], 16'ha5c3 ^ i[15:0]);
      rd_reg(mpo_pkg::OFF_DEAD_VALUES + i[3:0], 16'ha5c3 ^ i[15:0]);
    end
    wr_reg(4'h9, 16'hffff);
    rd_reg(4'h9, 16'h0000);
    wr_reg(mpo_pkg::OFF_OVERRIDE, 16'h0000);
    // Random immediate writes, lockout set and count parked at 100
    indep <= 4'hf;
    run <= 1'b1;
    lock <= 1'b1;
    wr_reg(mpo_pkg::OFF_MODE_CTRL, 16'h001f);
    for (int i = 0; i < 8; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      act[i % 4] = {8'h00, lfsr[7:0]};
      wr_reg(mpo_pkg::OFF_DUTY0 + i[3:0] % 4'h4, act[i % 4]);
      pins(1'b0, above(), above());
    end
    wr_reg(mpo_pkg::OFF_MODE_CTRL, 16'h000f);
    run <= 1'b0;
    boundary(mpo_pkg::MODE_FREE_RUN, 15'h0064, 1'b0, 1'b0, 1'b0);
    lock <= 1'b0;
    step(3);
    act[0] = (act[0] > 16'h0064) ? 16'h0000 : 16'h00c8;
    pins(1'b0, above(), above());
    run <= 1'b1;
    boundary(mpo_pkg::MODE_FREE_RUN, 15'h0064, 1'b0, 1'b1, 1'b1);
    boundary(mpo_pkg::MODE_FREE_RUN, 15'h0064, 1'b0, 1'b0, 1'b0);
    boundary(mpo_pkg::MODE_UP_DOWN, 15'h0000, 1'b1, 1'b0, 1'b0);
    boundary(mpo_pkg::MODE_UP_DOWN, 15'h0000, 1'b0, 1'b0, 1'b1);
    boundary(mpo_pkg::MODE_UP_DOWN, 15'h0064, 1'b0, 1'b1, 1'b0);
    boundary(mpo_pkg::MODE_UP_DOWN_DOUBLE, 15'h0064, 1'b0, 1'b1, 1'b1);
    boundary(mpo_pkg::MODE_UP_DOWN_DOUBLE, 15'h0000, 1'b1, 1'b0, 1'b1);
    lock <= 1'b1;
    boundary(mpo_pkg::MODE_FREE_RUN, 15'h0064, 1'b0, 1'b1, 1'b0);
    lock <= 1'b0;
    ab = above();
    wr_reg(mpo_pkg::OFF_OVERRIDE, 16'h0302);
    pins(1'b0, {ab[3:1], 1'b1}, {ab[3:1], 1'b0});
    wr_reg(mpo_pkg::OFF_OVERRIDE, 16'h0301);
    pins(1'b0, {ab[3:1], 1'b0}, {ab[3:1], 1'b1});
    wr_reg(mpo_pkg::OFF_OVERRIDE, 16'h0000);
    // Dead time: quiet all pairs before going complementary
    run <= 1'b0;
    wr_reg(mpo_pkg::OFF_MODE_CTRL, 16'h001f);
    for (int i = 0; i < 4; i++) wr_reg(mpo_pkg::OFF_DUTY0 + i[3:0], 16'h0000);
    indep <= 4'h0;
    wr_reg(mpo_pkg::OFF_MODE_CTRL, 16'h0010);
    wr_reg(mpo_pkg::OFF_DEAD_VALUES, 16'h0583);
    wr_reg(mpo_pkg::OFF_DEAD_ASSIGN, 16'h0002);
    step(20);
    pins(1'b0, 4'h0, 4'hf);
    wr_reg(mpo_pkg::OFF_DUTY0, 16'h00c8);
    dead_gap(1'b1, 10, 13);
    step(5);
    wr_reg(mpo_pkg::OFF_DUTY0, 16'h0000);
    dead_gap(1'b0, 3, 6);
    // Single pulse on pair zero, independent
    indep <= 4'h1;
    mode <= mpo_pkg::MODE_SINGLE_PULSE;
    cnt <= 15'h0005;
    wr_reg(mpo_pkg::OFF_MODE_CTRL, 16'h0011);
    wr_reg(mpo_pkg::OFF_DUTY0, 16'h00c8);
    step(2);
    pins(1'b0, 4'h0, 4'he);
    run <= 1'b1;
    step(3);
    pins(1'b0, 4'h1, 4'hf);
    pm <= 1'b1;
    @(posedge ref_clk_in);
    // End pulse stands one cycle only; the timebase drops its run flag with it
    pm <= 1'b0;
    run <= 1'b0;
    pins(1'b1, 4'h1, 4'hf);
    pins(1'b0, 4'h0, 4'he);
    check(shoot === 4'h0, "pair overlap");
    end_of_test();
  end
endmodule : tb
